// File: pll_synth_pkg.sv
package pll_synth_pkg;
  // Crystal and controller clock rates
  localparam int XTAL_FREQ_KHZ = 7200;
  localparam int CTL_CLK_FREQ_KHZ = 400;
  localparam int CTL_CLK_DIV_TB = XTAL_FREQ_KHZ / CTL_CLK_FREQ_KHZ;
  localparam int CTL_CLK_HIGH_TB = 12;
  localparam int CTL_CLK_LOW_TB = CTL_CLK_DIV_TB - CTL_CLK_HIGH_TB;
  // Serial frame layout
  localparam int FRAME_BITS = 36;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 16;
  localparam int DIRECT_W = 12;
  localparam int SWALLOW_POS = 16;
  localparam int SELECT_POS = 17;
  // Divider counter width, holds 65536
  localparam int RATIO_W = 17;
  // Reset values of the control word
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0100;
  localparam logic SWALLOW_RESET = 1'b0;
  localparam logic SELECT_RESET = 1'b0;
  // Default reference period in timebase cycles
  localparam int REF_DIV_TB_DEFAULT = 720;
  // Synchronized pin indices
  localparam int PIN_XTAL = 0;
  localparam int PIN_CE = 1;
  localparam int PIN_SHCLK = 2;
  localparam int PIN_SDATA = 3;
  localparam int PIN_HB = 4;
  localparam int PIN_LB = 5;
  localparam int PIN_N = 6;
endpackage : pll_synth_pkg

// File: prog_divider.sv
`timescale 1ns/10ps
// Counts input edge pulses and pulses once every ratio edges
module prog_divider
  import pll_synth_pkg::*;
#(
  parameter int W = RATIO_W
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic edge_in, // One pulse per input edge
  input wire logic [W-1:0] ratio, // Division ratio, at least 1
  output logic div_pulse // One pulse per ratio edges
);
  logic [W-1:0] count; // Edges seen this period
  logic [W-1:0] last; // Terminal count

  assign last = ratio - {{(W-1){1'b0}}, 1'b1};

  // Count edges, wrap at terminal count; >= tolerates a ratio change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      div_pulse <= 1'b0;
    end else begin
      div_pulse <= 1'b0;
      if (edge_in) begin
        if (count >= last) begin // Period complete
          count <= '0;
          div_pulse <= 1'b1;
        end else begin // Keep counting
          count <= count + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule : prog_divider

// File: pll_synth_core.sv
`timescale 1ns/10ps
// Synthesizer core: serial control, divider chain, comparator, clocks
module pll_synth_core
  import pll_synth_pkg::*;
#(
  parameter int REF_DIV_TB = REF_DIV_TB_DEFAULT // Timebase cycles per reference period
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rstn, // Async power-on reset, active low
  input wire logic crystal_in, // Crystal timebase pin
  output logic crystal_out, // Inverted crystal drive
  input wire logic chip_enable, // Serial select from controller
  input wire logic serial_shift_clock, // Serial shift clock
  input wire logic serial_data_in, // Serial data
  input wire logic high_band_osc_input, // High-band local oscillator
  input wire logic low_band_osc_input, // Low-band local oscillator
  output logic charge_pump_out_a, // Pump A level when driven
  output logic charge_pump_out_a_oe, // Pump A drive enable
  output logic charge_pump_out_b, // Pump B level when driven
  output logic charge_pump_out_b_oe, // Pump B drive enable
  output logic controller_clock_out, // Open-drain level, always low
  output logic controller_clock_out_oe // Pulls pin low when high
);
  // Rising edge detect on a synchronized level
  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : rise

  // Falling edge detect on a synchronized level
  function automatic logic fall(input logic now, input logic prev);
    return ~now & prev;
  endfunction : fall

  logic [PIN_N-1:0] pins; // Raw pin vector
  logic [PIN_N-1:0] sync1; // First synchronizer stage
  logic [PIN_N-1:0] sync2; // Second synchronizer stage
  logic [PIN_N-1:0] prev; // Delayed copy for edges

  assign pins = {low_band_osc_input, high_band_osc_input, serial_data_in,
                 serial_shift_clock, chip_enable, crystal_in};

  // Two-stage synchronizer plus edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  logic tb_tick; // One pulse per crystal cycle
  logic shift_tick; // Shift clock rising edge
  logic frame_end; // Select line falling edge
  logic hb_edge; // High-band rising edge
  logic lb_edge; // Low-band rising edge

  assign tb_tick = rise(sync2[PIN_XTAL], prev[PIN_XTAL]);
  assign shift_tick = rise(sync2[PIN_SHCLK], prev[PIN_SHCLK]);
  assign frame_end = fall(sync2[PIN_CE], prev[PIN_CE]);
  assign hb_edge = rise(sync2[PIN_HB], prev[PIN_HB]);
  assign lb_edge = rise(sync2[PIN_LB], prev[PIN_LB]);

  // Crystal drive is the inverted input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crystal_out <= 1'b1;
    end else begin
      crystal_out <= ~sync2[PIN_XTAL];
    end
  end

  logic [FRAME_BITS-1:0] shreg; // Incoming serial word
  logic [5:0] bit_count; // Bits in this frame, saturating

  // Shift data on shift clock rising edge while select is high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shreg <= '0;
      bit_count <= '0;
    end else if (!sync2[PIN_CE]) begin // Idle: restart count
      bit_count <= '0;
    end else if (shift_tick) begin
      shreg <= {shreg[FRAME_BITS-2:0], sync2[PIN_SDATA]};
      if (bit_count != 6'h3f) begin
        bit_count <= bit_count + 6'h01;
      end
    end
  end

  logic [DIV_W-1:0] divisor; // Programmed divisor field
  logic swallow_mode_bit; // Low band: 1 swallow counter, 0 direct
  logic input_select_bit; // 1 high band, 0 low band

  // Latch control word at frame end when exactly full
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divisor <= DIV_RESET;
      swallow_mode_bit <= SWALLOW_RESET;
      input_select_bit <= SELECT_RESET;
    end else if (frame_end && bit_count == 6'(FRAME_BITS)) begin
      divisor <= shreg[DIV_LSB +: DIV_W];
      swallow_mode_bit <= shreg[SWALLOW_POS];
      input_select_bit <= shreg[SELECT_POS];
    end
  end

  logic prescale; // Divide-by-two toggle
  logic hb_half; // High band after prescaler

  // Fixed prescaler on the high-band path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescale <= 1'b0;
    end else if (hb_edge) begin
      prescale <= ~prescale;
    end
  end

  assign hb_half = hb_edge & prescale;

  logic sel_edge; // Edges fed to divider
  logic [RATIO_W-1:0] ratio; // Effective counter ratio

  // Input and divider style selection
  always_comb begin
    if (input_select_bit) begin
      sel_edge = hb_half;
      ratio = (divisor == '0) ? 17'h10000 : {1'b0, divisor};
    end else if (swallow_mode_bit) begin
      sel_edge = lb_edge;
      ratio = (divisor == '0) ? 17'h10000 : {1'b0, divisor};
    end else begin
      sel_edge = lb_edge;
      ratio = (divisor[DIRECT_W-1:0] == '0) ? 17'h01000 :
              {5'h00, divisor[DIRECT_W-1:0]};
    end
  end

  logic div_pulse; // Divided oscillator pulse

  prog_divider #(
    .W(RATIO_W)
  ) u_divider (
    .clk(clk),
    .rstn(rstn),
    .edge_in(sel_edge),
    .ratio(ratio),
    .div_pulse(div_pulse)
  );

  logic [15:0] ref_count; // Timebase cycles this reference period
  logic ref_pulse; // Reference frequency pulse

  // Reference from timebase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_count <= '0;
      ref_pulse <= 1'b0;
    end else begin
      ref_pulse <= 1'b0;
      if (tb_tick) begin
        if (ref_count >= 16'(REF_DIV_TB - 1)) begin
          ref_count <= '0;
          ref_pulse <= 1'b1;
        end else begin
          ref_count <= ref_count + 16'h0001;
        end
      end
    end
  end

  logic up; // Divided edge arrived first
  logic dn; // Reference edge arrived first
  logic next_up; // Next up state
  logic next_dn; // Next down state

  // Phase-frequency comparator, clear when both have arrived
  always_comb begin
    next_up = up | div_pulse;
    next_dn = dn | ref_pulse;
    if (next_up && next_dn) begin // Matched
      next_up = 1'b0;
      next_dn = 1'b0;
    end
  end

  // Comparator state and pump drivers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up <= 1'b0;
      dn <= 1'b0;
      charge_pump_out_a <= 1'b0;
      charge_pump_out_a_oe <= 1'b0;
      charge_pump_out_b <= 1'b0;
      charge_pump_out_b_oe <= 1'b0;
    end else begin
      up <= next_up;
      dn <= next_dn;
      charge_pump_out_a <= next_up;
      charge_pump_out_b <= next_up;
      charge_pump_out_a_oe <= next_up | next_dn;
      charge_pump_out_b_oe <= next_up | next_dn;
    end
  end

  logic [4:0] ctl_clk_count; // Timebase phase of controller clock

  // Controller clock: 12 timebase cycles high, 6 low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_clk_count <= '0;
      controller_clock_out_oe <= 1'b0;
    end else begin
      if (tb_tick) begin
        if (ctl_clk_count >= 5'(CTL_CLK_DIV_TB - 1)) begin
          ctl_clk_count <= '0;
        end else begin
          ctl_clk_count <= ctl_clk_count + 5'h01;
        end
      end
      controller_clock_out_oe <= (ctl_clk_count >= 5'(CTL_CLK_HIGH_TB));
    end
  end

  assign controller_clock_out = 1'b0; // Open drain only pulls low
endmodule : pll_synth_core

// File: pll_synth_chk.sv
`timescale 1ns/10ps
// Pin checks on pump, timebase and controller clock
module pll_synth_chk (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic crystal_in, // Timebase in
  input wire logic crystal_out, // Timebase out
  input wire logic charge_pump_out_a, // Pump A
  input wire logic charge_pump_out_a_oe, // Pump A enable
  input wire logic charge_pump_out_b, // Pump B
  input wire logic charge_pump_out_b_oe, // Pump B enable
  input wire logic controller_clock_out, // Clock level
  input wire logic controller_clock_out_oe // Clock pull-down
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic prev; // Last enable
  logic seen; // First edge passed
  logic [9:0] run; // Cycles in this state
  // Length of each controller clock state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev <= 1'b0;
      seen <= 1'b0;
      run <= 10'h000;
    end else if (controller_clock_out_oe != prev) begin
      prev <= controller_clock_out_oe;
      seen <= 1'b1;
      run <= 10'h001;
    end else begin
      run <= run + 10'h001;
    end
  end
  sequence s_pulled;
    controller_clock_out_oe && !prev && seen;
  endsequence
  sequence s_released;
    !controller_clock_out_oe && prev && seen;
  endsequence
  a_clk_high_time: assert property (s_pulled |-> run >= 10'h14a && run <= 10'h154)
    else $error("pin high time wrong");
  a_clk_low_time: assert property (s_released |-> run >= 10'h0a4 && run <= 10'h0ac)
    else $error("pin low time wrong");
  a_clk_open_drain: assert property (controller_clock_out == 1'b0)
    else $error("clock level not low");
  a_xtal_rise_out: assert property ($rose(crystal_in) |-> ##[1:4] !crystal_out)
    else $error("crystal drive missed rise");
  a_xtal_fall_out: assert property ($fell(crystal_in) |-> ##[1:4] crystal_out)
    else $error("crystal drive missed fall");
  a_pump_oe_pair: assert property (charge_pump_out_a_oe == charge_pump_out_b_oe)
    else $error("pump enables differ");
  a_pump_lvl_pair: assert property (charge_pump_out_a_oe |-> charge_pump_out_a == charge_pump_out_b)
    else $error("pump levels differ");
  a_pump_no_flip: assert property (charge_pump_out_a_oe && $past(charge_pump_out_a_oe)
    |-> $stable(charge_pump_out_a))
    else $error("pump flipped without float");
endmodule : pll_synth_chk

bind pll_synth_core pll_synth_chk i_chk (.clk(clk), .rstn(rstn), .crystal_in(crystal_in),
  .crystal_out(crystal_out), .charge_pump_out_a(charge_pump_out_a),
  .charge_pump_out_a_oe(charge_pump_out_a_oe), .charge_pump_out_b(charge_pump_out_b),
  .charge_pump_out_b_oe(charge_pump_out_b_oe), .controller_clock_out(controller_clock_out),
  .controller_clock_out_oe(controller_clock_out_oe));

// File: ctrl_model.sv
`timescale 1ns/10ps
// Controller side of the serial link
module ctrl_model (
  output logic chip_enable, // Select
  output logic serial_shift_clock, // Shift clock
  output logic serial_data_in // Data
);
  // Idle link
  initial begin
    chip_enable = 1'b0;
    serial_shift_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // Sends the low n bits, highest first; clock still between frames
  task automatic send_frame(input logic [35:0] word, input int n);
    int i;
    chip_enable <= 1'b1;
    for (i = n - 1; i >= 0; i--) begin
      serial_data_in <= word[i];
      #24 serial_shift_clock <= 1'b1;
      #24 serial_shift_clock <= 1'b0;
    end
    #24 chip_enable <= 1'b0;
    serial_data_in <= ~serial_data_in;
  endtask : send_frame
endmodule : ctrl_model

// File: pll_divider_phase_compare_tb_top.sv
`timescale 1ns/10ps
// Bench: loads ratios, judges pump direction and clock duty
module pll_divider_phase_compare_tb_top import pll_synth_pkg::*;;
  logic clk = 1'b0; // Clock
  logic rstn = 1'b0; // Reset
  logic crystal_in = 1'b0; // Timebase
  logic high_band_osc_input = 1'b0; // High band
  logic low_band_osc_input = 1'b0; // Low band
  wire chip_enable, serial_shift_clock, serial_data_in; // Link
  logic pa, pa_oe, pb, pb_oe, ck, ck_oe; // Outputs
  int ph = 0; // Cycle count
  int fails = 0; // Mismatches
  int tests_run = 0; // Compares
  always #2.5 clk = ~clk;
  // Timebase 140 ns, bands 40 ns and 50 ns, timeout
  always @(posedge clk) begin
    ph <= ph + 1;
    if (ph % 14 == 13) crystal_in <= ~crystal_in;
    if (ph % 4 == 3) high_band_osc_input <= ~high_band_osc_input;
    if (ph % 5 == 4) low_band_osc_input <= ~low_band_osc_input;
    if (ph == 90000) begin
      $display("[ERR] %0t timeout", $time);
      fails++;
      give_verdict();
    end
  end
  pll_synth_core #(.REF_DIV_TB(72)) i_dut (.clk(clk), .rstn(rstn), .crystal_in(crystal_in),
    .crystal_out(), .chip_enable(chip_enable), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .high_band_osc_input(high_band_osc_input),
    .low_band_osc_input(low_band_osc_input), .charge_pump_out_a(pa), .charge_pump_out_a_oe(pa_oe),
    .charge_pump_out_b(pb), .charge_pump_out_b_oe(pb_oe), .controller_clock_out(ck),
    .controller_clock_out_oe(ck_oe));
  ctrl_model i_ctrl (.chip_enable(chip_enable), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in));
  // Count in range
  task cmp_cnt(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      fails++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : cmp_cnt
  // Loads a word, lets the loop settle past two reference periods
  task load(input logic sel, input logic swl, input logic [15:0] div, input int n);
    logic [FRAME_BITS-1:0] w;
    w = '0;
    w[DIV_LSB +: DIV_W] = div;
    w[SWALLOW_POS] = swl;
    w[SELECT_POS] = sel;
    i_ctrl.send_frame(w, n);
    repeat (4500) @(posedge clk);
  endtask : load
  // Samples 6000 cycles: pump states and clock duty
  // Ratios at least twice apart from reference, so no phase drift
  task check_pump(input bit fast, input bit flt);
    int hi, lo, fl, up;
    hi = 0;
    lo = 0;
    fl = 0;
    up = 0;
    repeat (6000) begin
      @(negedge clk);
      if (pa_oe === 1'b0) fl++;
      else if (pa === 1'b1 && pa_oe === 1'b1) hi++;
      else if (pa === 1'b0 && pa_oe === 1'b1) lo++;
      if (ck_oe === 1'b0) up++;
    end
    cmp_cnt(fast ? lo : hi, 0, 0);
    cmp_cnt(fast ? hi : lo, 1, 6000);
    cmp_cnt(fl, flt ? 1 : 0, flt ? 6000 : 0);
    cmp_cnt(up / 60, 64, 69);
  endtask : check_pump
  task t_high_slow;
    load(1'b1, 1'b0, 16'h0120, FRAME_BITS);
    check_pump(1'b0, 1'b1);
    $display("high band slow done");
  endtask : t_high_slow
  task t_high_fast;
    load(1'b1, 1'b0, 16'h0030, FRAME_BITS);
    check_pump(1'b1, 1'b1);
    $display("high band fast done");
  endtask : t_high_fast
  task t_low_swallow;
    load(1'b0, 1'b1, 16'h0050, FRAME_BITS);
    check_pump(1'b1, 1'b1);
    $display("low swallow done");
  endtask : t_low_swallow
  task t_low_direct;
    load(1'b0, 1'b0, 16'h1050, FRAME_BITS);
    check_pump(1'b1, 1'b1);
    $display("low direct done");
  endtask : t_low_direct
  task t_low_big;
    // Divided period far beyond the window: pump held low, never floats
    load(1'b0, 1'b1, 16'h1050, FRAME_BITS);
    check_pump(1'b0, 1'b0);
    $display("low swallow big done");
  endtask : t_low_big
  task t_short_frame;
    load(1'b0, 1'b0, 16'h1050, FRAME_BITS - 1);
    check_pump(1'b0, 1'b0);
    $display("short frame done");
  endtask : t_short_frame
  task give_verdict;
    $display("Counts: %0d compared, %0d failed", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_high_slow();
    t_high_fast();
    t_low_swallow();
    t_low_direct();
    t_low_big();
    t_short_frame();
    give_verdict();
  end
endmodule : pll_divider_phase_compare_tb_top
